//--- dag_top.sv
`timescale 1ns/100ps
// Behaviour
// - Byte-addressed data space split X and Y
// - General instructions use X unit only
// - Dual-operand ops drive X and Y together
// - Split only for dual ops, register dedicated
// - Any working register is pointer or offset
// - Circular buffers in X and Y spaces
// - Circular correction for any working register
// - Increment checks end, decrement checks start
// - Overshoot beyond boundary also wraps
// - Pre/post modify writes corrected address back
// - Register offset form leaves pointer unchanged
// - Bit reverse on X writes only
// - Only modifier is bit-reversed
// - Upper data half maps to program page, X path only
// - Register fifteen is the stack pointer
// - Reverse needs select not 15, enable, inc
// - Reverse adds pivot, ignores offset, clears LSB
module dag_top
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic op_valid,
  input wire logic op_dual,
  input wire logic op_write,
  input wire logic op_byte,
  input wire logic [2:0] op_xmode,
  input wire logic [3:0] op_xreg,
  input wire logic [3:0] op_xoff_reg,
  input wire logic [15:0] op_xstep,
  input wire logic [2:0] op_ymode,
  input wire logic [3:0] op_yreg,
  input wire logic [15:0] op_ystep,
  input wire logic wb_valid,
  input wire logic [3:0] wb_idx,
  input wire logic [15:0] wb_data,
  output logic [15:0] stack_pointer_register,
  output logic [15:0] x_effective_address,
  output logic x_addr_valid,
  output logic x_program_space,
  output logic [22:0] x_program_address,
  output logic [15:0] y_effective_address,
  output logic y_addr_valid
);
  import dag_pkg::*;

  typedef struct packed
  {
    logic [15:0] circ_ctrl;
    logic [15:0] x_start;
    logic [15:0] x_end;
    logic [15:0] y_start;
    logic [15:0] y_end;
    logic bit_reverse_enable;
    logic [14:0] reverse_pivot_modifier;
    logic [7:0] program_visibility_page;
    logic [15:0] y_split;
    logic [NUM_REGS*DATA_W-1:0] wregs;
    logic [15:0] rdata;
    logic [15:0] x_ea;
    logic x_vld;
    logic x_psv;
    logic [22:0] x_paddr;
    logic [15:0] y_ea;
    logic y_vld;
    logic x_wrapped;
    logic y_wrapped;
    logic rev_used;
  } dag_state_t;

  dag_state_t s_r;
  dag_state_t s_nxt;

  dag_circ_if xc();
  dag_circ_if yc();
  dag_circ_unit u_xcirc (.c(xc));
  dag_circ_unit u_ycirc (.c(yc));

  logic [15:0] x_ptr;
  logic [15:0] x_off;
  logic [15:0] x_raw;
  logic [15:0] x_new_ptr;
  logic [15:0] y_ptr;
  logic [15:0] y_raw;
  logic [15:0] y_new_ptr;
  logic [15:0] rev_addr;
  logic [15:0] pivot_b;
  logic [15:0] rev_ea;
  logic rev_active;
  logic x_circ_on;
  logic y_circ_on;
  logic [3:0] rev_sel;

  function automatic logic [15:0] rd_reg(input logic [NUM_REGS*DATA_W-1:0] r,
    input logic [3:0] i);
    rd_reg = r[i*DATA_W +: DATA_W];
  endfunction : rd_reg

  // Pre-forms use the stepped value; post-forms the old pointer.
  function automatic logic [15:0] step_addr(input logic [2:0] m, input logic [15:0] p,
    input logic [15:0] st);
    case (m)
      MODE_PRE_INC: step_addr = 16'(p + st);
      MODE_PRE_DEC: step_addr = 16'(p - st);
      default: step_addr = p;
    endcase
  endfunction : step_addr

  function automatic logic [15:0] next_ptr(input logic [2:0] m, input logic [15:0] p,
    input logic [15:0] st);
    case (m)
      MODE_POST_INC, MODE_PRE_INC: next_ptr = 16'(p + st);
      MODE_POST_DEC, MODE_PRE_DEC: next_ptr = 16'(p - st);
      default: next_ptr = p;
    endcase
  endfunction : next_ptr

  function automatic logic is_inc(input logic [2:0] m);
    is_inc = (m == MODE_POST_INC) || (m == MODE_PRE_INC) || (m == MODE_REG_OFFSET)
      || (m == MODE_DIRECT);
  endfunction : is_inc

  function automatic logic is_modify(input logic [2:0] m);
    is_modify = (m == MODE_POST_INC) || (m == MODE_POST_DEC) || (m == MODE_PRE_INC)
      || (m == MODE_PRE_DEC);
  endfunction : is_modify

  always_comb
  begin
    x_ptr = rd_reg(s_r.wregs, op_xreg);
    x_off = rd_reg(s_r.wregs, op_xoff_reg);
    y_ptr = rd_reg(s_r.wregs, op_yreg);
    rev_sel = s_r.circ_ctrl[MC_REVSEL_LSB +: 4];
    x_raw = (op_xmode == MODE_REG_OFFSET) ? 16'(x_ptr + x_off)
      : step_addr(op_xmode, x_ptr, op_xstep);
    x_new_ptr = next_ptr(op_xmode, x_ptr, op_xstep);
    y_raw = step_addr(op_ymode, y_ptr, op_ystep);
    y_new_ptr = next_ptr(op_ymode, y_ptr, op_ystep);
    // The stack cannot be reversed; only word writes with pre/post increment.
    rev_active = (rev_sel != STACK_IDX) && s_r.bit_reverse_enable && (op_xreg == rev_sel)
      && ((op_xmode == MODE_PRE_INC) || (op_xmode == MODE_POST_INC))
      && op_write && !op_byte;
    // The pivot is word-scaled, and reversal ignores the step.
    pivot_b = {s_r.reverse_pivot_modifier, 1'b0};
    rev_ea = x_ptr;
    // Reverse-carry add across the bits up to the pivot span.
    begin : revadd
      logic c;
      c = 1'b0;
      for (int b = 15; b >= 1; b--)
      begin
        if ((16'h0001 << b) <= pivot_b)
        begin
          rev_ea[b] = x_ptr[b] ^ pivot_b[b] ^ c;
          c = (x_ptr[b] & pivot_b[b]) | (c & (x_ptr[b] ^ pivot_b[b]));
        end
      end
    end
    rev_ea[0] = 1'b0;
    // Post-increment hands out the old pointer and only stores the reversed sum.
    rev_addr = (op_xmode == MODE_POST_INC) ? {x_ptr[15:1], 1'b0} : rev_ea;
    // Reversed addressing takes priority and disables X circular correction.
    x_circ_on = s_r.circ_ctrl[MC_XEN_BIT] && (op_xreg == s_r.circ_ctrl[MC_XREG_LSB +: 4])
      && !rev_active;
    y_circ_on = s_r.circ_ctrl[MC_YEN_BIT] && (op_yreg == s_r.circ_ctrl[MC_YREG_LSB +: 4])
      && op_dual;
    xc.addr = x_raw;
    xc.start_addr = s_r.x_start;
    xc.end_addr = s_r.x_end;
    xc.enable = x_circ_on;
    xc.incrementing = is_inc(op_xmode);
    yc.addr = y_raw;
    yc.start_addr = s_r.y_start;
    yc.end_addr = s_r.y_end;
    yc.enable = y_circ_on;
    yc.incrementing = is_inc(op_ymode);
  end

  // Second circular check for the written-back pointer of pre- and post-modify forms.
  dag_circ_if xw();
  dag_circ_if yw();
  dag_circ_unit u_xwb (.c(xw));
  dag_circ_unit u_ywb (.c(yw));
  always_comb
  begin
    xw.addr = x_new_ptr;
    xw.start_addr = s_r.x_start;
    xw.end_addr = s_r.x_end;
    xw.enable = x_circ_on;
    xw.incrementing = is_inc(op_xmode);
    yw.addr = y_new_ptr;
    yw.start_addr = s_r.y_start;
    yw.end_addr = s_r.y_end;
    yw.enable = y_circ_on;
    yw.incrementing = is_inc(op_ymode);
  end

  always_comb
  begin
    logic [15:0] xea;
    logic [15:0] yea;
    xea = 16'h0000;
    yea = 16'h0000;
    s_nxt = s_r;
    s_nxt.rdata = 16'h0000;
    s_nxt.x_vld = 1'b0;
    s_nxt.y_vld = 1'b0;
    if (reg_wr)
    begin
      case (reg_addr)
        ADDR_MODCTRL: s_nxt.circ_ctrl = reg_wdata;
        ADDR_XSTART: s_nxt.x_start = reg_wdata;
        ADDR_XEND: s_nxt.x_end = reg_wdata;
        ADDR_YSTART: s_nxt.y_start = reg_wdata;
        ADDR_YEND: s_nxt.y_end = reg_wdata;
        ADDR_REVCTRL:
        begin
          s_nxt.bit_reverse_enable = reg_wdata[RC_EN_BIT];
          s_nxt.reverse_pivot_modifier = reg_wdata[14:0];
        end
        ADDR_PSVPAGE: s_nxt.program_visibility_page = reg_wdata[7:0];
        ADDR_YSPLIT: s_nxt.y_split = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_MODCTRL: s_nxt.rdata = s_r.circ_ctrl;
        ADDR_XSTART: s_nxt.rdata = s_r.x_start;
        ADDR_XEND: s_nxt.rdata = s_r.x_end;
        ADDR_YSTART: s_nxt.rdata = s_r.y_start;
        ADDR_YEND: s_nxt.rdata = s_r.y_end;
        ADDR_REVCTRL: s_nxt.rdata = {s_r.bit_reverse_enable, s_r.reverse_pivot_modifier};
        ADDR_PSVPAGE: s_nxt.rdata = {8'h00, s_r.program_visibility_page};
        ADDR_STATUS: s_nxt.rdata = {13'h0000, s_r.rev_used, s_r.y_wrapped, s_r.x_wrapped};
        ADDR_YSPLIT: s_nxt.rdata = s_r.y_split;
        default: s_nxt.rdata = 16'h0000;
      endcase
    end
    if (wb_valid)
    begin
      s_nxt.wregs[wb_idx*DATA_W +: DATA_W] = wb_data;
    end
    if (op_valid)
    begin
      // X unit serves every access; the whole map is linear for it.
      xea = rev_active ? rev_addr : xc.corrected;
      s_nxt.x_ea = xea;
      s_nxt.x_vld = 1'b1;
      s_nxt.x_wrapped = xc.wrapped;
      s_nxt.rev_used = rev_active;
      s_nxt.x_psv = xea[15];
      s_nxt.x_paddr = {s_r.program_visibility_page, xea[14:0]};
      if (is_modify(op_xmode))
      begin
        // Corrected address goes back to the pointer.
        s_nxt.wregs[op_xreg*DATA_W +: DATA_W] = rev_active ? rev_ea : xw.corrected;
      end
      if (op_dual)
      begin
        // Dual-operand reads split the space: Y at or above the split.
        yea = yc.corrected;
        s_nxt.y_ea = yea;
        s_nxt.y_vld = (yea >= s_r.y_split);
        s_nxt.y_wrapped = yc.wrapped;
        if (is_modify(op_ymode))
        begin
          s_nxt.wregs[op_yreg*DATA_W +: DATA_W] = yw.corrected;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_r <= '0;
      s_r.circ_ctrl[MC_REVSEL_LSB +: 4] <= REV_SEL_RESET;
      s_r.program_visibility_page <= PSV_PAGE_RESET;
      s_r.reverse_pivot_modifier <= PIVOT_RESET;
      s_r.y_split <= YSPLIT_DEFAULT;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign stack_pointer_register = rd_reg(s_r.wregs, STACK_IDX);
  assign x_effective_address = s_r.x_ea;
  assign x_addr_valid = s_r.x_vld;
  assign x_program_space = s_r.x_psv;
  assign x_program_address = s_r.x_paddr;
  assign y_effective_address = s_r.y_ea;
  assign y_addr_valid = s_r.y_vld;
endmodule : dag_top

//--- dag_pkg.sv
package dag_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NUM_REGS = 16;
  localparam logic [3:0] STACK_IDX = 4'hF;
  localparam logic [15:0] PSV_WINDOW_BIT = 16'h8000;
  localparam logic [7:0] PSV_PAGE_RESET = 8'h00;
  localparam logic [3:0] REV_SEL_RESET = 4'hF;
  localparam logic [14:0] PIVOT_RESET = 15'h0000;
  localparam logic [15:0] MOD_BOUND_RESET = 16'h0000;
  localparam logic [15:0] YSPLIT_DEFAULT = 16'h0C00;

  // Register port map, word offsets on the plain register port.
  localparam logic [3:0] ADDR_MODCTRL = 4'h0;
  localparam logic [3:0] ADDR_XSTART = 4'h1;
  localparam logic [3:0] ADDR_XEND = 4'h2;
  localparam logic [3:0] ADDR_YSTART = 4'h3;
  localparam logic [3:0] ADDR_YEND = 4'h4;
  localparam logic [3:0] ADDR_REVCTRL = 4'h5;
  localparam logic [3:0] ADDR_PSVPAGE = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  localparam logic [3:0] ADDR_YSPLIT = 4'h8;

  // Circular and reverse control field positions.
  localparam int unsigned MC_XEN_BIT = 15;
  localparam int unsigned MC_YEN_BIT = 14;
  localparam int unsigned MC_REVSEL_LSB = 8;
  localparam int unsigned MC_YREG_LSB = 4;
  localparam int unsigned MC_XREG_LSB = 0;
  localparam int unsigned RC_EN_BIT = 15;

  typedef enum logic [2:0]
  {
    MODE_DIRECT = 3'b000,
    MODE_POST_INC = 3'b001,
    MODE_POST_DEC = 3'b010,
    MODE_PRE_INC = 3'b011,
    MODE_PRE_DEC = 3'b100,
    MODE_REG_OFFSET = 3'b101
  } dag_mode_t;
endpackage : dag_pkg

//--- dag_circ_if.sv
`timescale 1ns/100ps
interface dag_circ_if;
  logic [15:0] addr;
  logic [15:0] start_addr;
  logic [15:0] end_addr;
  logic enable;
  logic incrementing;
  logic [15:0] corrected;
  logic wrapped;
  modport unit (input addr, input start_addr, input end_addr, input enable,
    input incrementing, output corrected, output wrapped);
  modport user (output addr, output start_addr, output end_addr, output enable,
    output incrementing, input corrected, input wrapped);
endinterface : dag_circ_if

//--- dag_circ_unit.sv
`timescale 1ns/100ps
module dag_circ_unit
(
  dag_circ_if.unit c
);
  import dag_pkg::*;
  logic [15:0] len;
  logic over;
  logic under;
  always_comb
  begin
    len = 16'(c.end_addr - c.start_addr + 16'h0001);
    // Beyond, not only equal: an overshoot of up to one buffer length still lands inside.
    over = c.incrementing && (c.addr > c.end_addr);
    under = !c.incrementing && (c.addr < c.start_addr);
    c.wrapped = c.enable && (over || under);
    c.corrected = c.addr;
    if (c.enable && over)
    begin
      c.corrected = 16'(c.addr - len);
    end
    else if (c.enable && under)
    begin
      c.corrected = 16'(c.addr + len);
    end
  end
endmodule : dag_circ_unit

//--- dag_asserts.sv
`timescale 1ns/100ps
module dag_asserts
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic op_valid,
  input wire logic op_dual,
  input wire logic wb_valid,
  input wire logic [15:0] stack_pointer_register,
  input wire logic [15:0] x_effective_address,
  input wire logic x_addr_valid,
  input wire logic x_program_space,
  input wire logic [22:0] x_program_address,
  input wire logic y_addr_valid
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  x_lat_a: assert property (op_valid |=> x_addr_valid)
    else $error("x address not valid one cycle after request");
  x_cause_a: assert property (x_addr_valid |-> $past(op_valid))
    else $error("x address valid without request");
  y_dual_a: assert property (y_addr_valid |-> $past(op_valid && op_dual))
    else $error("y address valid without dual request");
  psv_flag_a: assert property (x_program_space == x_effective_address[15])
    else $error("program space flag differs from address bit 15");
  psv_addr_a: assert property (x_addr_valid |->
    x_program_address[14:0] == x_effective_address[14:0])
    else $error("program address low part differs");
  sp_hold_a: assert property (!$past(wb_valid) && !$past(op_valid) |->
    $stable(stack_pointer_register))
    else $error("stack pointer changed without cause");
  ea_hold_a: assert property (!x_addr_valid |-> $stable(x_effective_address))
    else $error("x address moved without request");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read slot");
endmodule : dag_asserts

bind dag_top dag_asserts u_dag_asserts(.mclk, .reset_n, .reg_rd, .reg_rdata, .op_valid,
  .op_dual, .wb_valid, .stack_pointer_register, .x_effective_address, .x_addr_valid,
  .x_program_space, .x_program_address, .y_addr_valid);

//--- dag_ctrl_model.sv
`timescale 1ns/100ps
module dag_ctrl_model
(
  input wire logic mclk,
  output logic op_valid,
  output logic op_dual,
  output logic op_write,
  output logic op_byte,
  output logic [2:0] op_xmode,
  output logic [3:0] op_xreg,
  output logic [3:0] op_xoff_reg,
  output logic [15:0] op_xstep,
  output logic [2:0] op_ymode,
  output logic [3:0] op_yreg,
  output logic [15:0] op_ystep,
  output logic wb_valid,
  output logic [3:0] wb_idx,
  output logic [15:0] wb_data
);
  initial
  begin
    {op_valid, op_dual, op_write, op_byte, op_xmode, op_xreg, op_xoff_reg} = '0;
    {op_xstep, op_ymode, op_yreg, op_ystep, wb_valid, wb_idx, wb_data} = '0;
  end
  task wr_reg(input logic [3:0] i, input logic [15:0] d);
    @(posedge mclk);
    {wb_valid, wb_idx, wb_data} <= {1'h1, i, d};
    @(posedge mclk);
    {wb_valid, wb_data} <= {1'h0, ~d};
  endtask : wr_reg
  // Steps are inverted once released so a stale value is never mistaken for a live one.
  task issue(input logic d, w, input logic [2:0] xm, input logic [3:0] xr, xo,
    input logic [15:0] xs, input logic [2:0] ym, input logic [3:0] yr, input logic [15:0] ys);
    @(posedge mclk);
    {op_valid, op_dual, op_write, op_xmode, op_xreg, op_xoff_reg} <= {1'h1, d, w, xm, xr, xo};
    {op_xstep, op_ymode, op_yreg, op_ystep} <= {xs, ym, yr, ys};
    @(posedge mclk);
    {op_valid, op_xstep, op_ystep} <= {1'h0, ~xs, ~ys};
    #1;
  endtask : issue
  // Byte width stays in force for every later request until it is changed again.
  task byte_mode(input logic b);
    @(posedge mclk);
    op_byte <= b;
  endtask : byte_mode
endmodule : dag_ctrl_model

//--- dag_top_tb.sv
`timescale 1ns/100ps
module dag_top_tb;
  import dag_pkg::*;
  logic mclk = 1'h0;
  logic reset_n, reg_wr, reg_rd, op_valid, op_dual, op_write, op_byte, wb_valid;
  logic x_addr_valid, x_program_space, y_addr_valid;
  logic [2:0] op_xmode, op_ymode, m;
  logic [3:0] reg_addr, op_xreg, op_xoff_reg, op_yreg, wb_idx, k, o;
  logic [15:0] reg_wdata, reg_rdata, op_xstep, op_ystep, wb_data, stack_pointer_register;
  logic [15:0] x_effective_address, y_effective_address, p, s, e;
  logic [22:0] x_program_address;
  integer seed = 32'h5E6625CB;
  logic [15:0] wm [16];
  int err_total = 0;
  int n_checks = 0;
  always #25 mclk = ~mclk;
  dag_top u_dag_top(.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .op_valid, .op_dual, .op_write, .op_byte, .op_xmode, .op_xreg, .op_xoff_reg, .op_xstep,
    .op_ymode, .op_yreg, .op_ystep, .wb_valid, .wb_idx, .wb_data, .stack_pointer_register,
    .x_effective_address, .x_addr_valid, .x_program_space, .x_program_address,
    .y_effective_address, .y_addr_valid);
  dag_ctrl_model u_dag_ctrl_model(.mclk, .op_valid, .op_dual, .op_write, .op_byte, .op_xmode,
    .op_xreg, .op_xoff_reg, .op_xstep, .op_ymode, .op_yreg, .op_ystep, .wb_valid, .wb_idx,
    .wb_data);
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    {reg_wr, reg_addr, reg_wdata} <= {1'h1, a, d};
    @(posedge mclk);
    {reg_wr, reg_wdata} <= {1'h0, ~d};
  endtask : wr
  task rd(input logic [3:0] a, input logic [15:0] x);
    @(posedge mclk);
    {reg_rd, reg_addr} <= {1'h1, a};
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1;
    chk("reg_rdata", x, reg_rdata);
  endtask : rd
  task ld(input logic [3:0] r, input logic [15:0] d);
    u_dag_ctrl_model.wr_reg(r, d);
    wm[r] = d;
  endtask : ld
  task xop(input logic w, input logic [2:0] md, input logic [3:0] r, ro,
    input logic [15:0] st, ea);
    u_dag_ctrl_model.issue(1'h0, w, md, r, ro, st, 3'h0, 4'h0, 16'h0000);
    chk("x_addr_valid", 1, x_addr_valid);
    chk("x_effective_address", ea, x_effective_address);
  endtask : xop
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // The whole sequence needs well under 400 cycles, so this only trips on a hang.
  initial
  begin
    #(3000 * 50);
    err_total++;
    final_report();
  end
  initial
  begin
    {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    wm = '{default: 16'h0000};
    repeat (8) @(posedge mclk);
    reset_n <= 1'h1;
    rd(ADDR_MODCTRL, 16'h0F00);
    rd(ADDR_REVCTRL, 16'h0000);
    rd(ADDR_PSVPAGE, 16'h0000);
    rd(ADDR_YSPLIT, YSPLIT_DEFAULT);
    rd(4'hF, 16'h0000);
    $display("test reset finished");
    for (int i = 0; i < 16; i++)
    begin
      k = 4'(i);
      o = k + 4'h1;
      m = 3'(i % 6);
      ld(k, 16'($random(seed)));
      s = 16'($random(seed)) & 16'h00FE;
      p = wm[k];
      e = (m == 3'h3) ? p + s : (m == 3'h4) ? p - s : (m == 3'h5) ? p + wm[o] : p;
      wm[k] = (m == 3'h1 || m == 3'h3) ? p + s : (m == 3'h2 || m == 3'h4) ? p - s : p;
      xop(1'h0, m, k, o, s, e);
      xop(1'h0, MODE_DIRECT, k, o, 16'h0000, wm[k]);
    end
    chk("stack_pointer_register", wm[15], stack_pointer_register);
    $display("test linear finished");
    wr(ADDR_PSVPAGE, 16'h00A5);
    rd(ADDR_PSVPAGE, 16'h00A5);
    ld(4'h3, 16'h9234);
    xop(1'h0, MODE_DIRECT, 4'h3, 4'h0, 16'h0000, 16'h9234);
    chk("x_program_space", 1, x_program_space);
    chk("x_program_address", {8'hA5, 15'h1234}, x_program_address);
    $display("test program page finished");
    wr(ADDR_XSTART, 16'h1000);
    wr(ADDR_XEND, 16'h101F);
    wr(ADDR_MODCTRL, 16'h8F04);
    ld(4'h4, 16'h101C);
    ld(4'h5, 16'h0010);
    xop(1'h0, MODE_PRE_INC, 4'h4, 4'h0, 16'h0008, 16'h1004);
    rd(ADDR_STATUS, 16'h0001);
    xop(1'h0, MODE_PRE_DEC, 4'h4, 4'h0, 16'h0006, 16'h101E);
    xop(1'h0, MODE_REG_OFFSET, 4'h4, 4'h5, 16'h0000, 16'h100E);
    xop(1'h0, MODE_POST_INC, 4'h4, 4'h0, 16'h0004, 16'h101E);
    xop(1'h0, MODE_DIRECT, 4'h4, 4'h0, 16'h0000, 16'h1002);
    $display("test circular x finished");
    wr(ADDR_YSTART, 16'h2000);
    wr(ADDR_YEND, 16'h200F);
    wr(ADDR_MODCTRL, 16'h4F90);
    ld(4'h9, 16'h200C);
    u_dag_ctrl_model.issue(1'h1, 1'h0, MODE_DIRECT, 4'h4, 4'h0, 16'h0, MODE_PRE_INC, 4'h9, 16'h6);
    chk("y_addr_valid", 1, y_addr_valid);
    chk("y_effective_address", 16'h2002, y_effective_address);
    chk("x_effective_address", 16'h1002, x_effective_address);
    rd(ADDR_STATUS, 16'h0002);
    u_dag_ctrl_model.issue(1'h0, 1'h0, MODE_DIRECT, 4'h4, 4'h0, 16'h0, MODE_DIRECT, 4'h9, 16'h0);
    chk("y_addr_valid", 0, y_addr_valid);
    $display("test dual finished");
    wr(ADDR_MODCTRL, 16'h0200);
    wr(ADDR_REVCTRL, 16'h8008);
    ld(4'h2, 16'h0000);
    for (int i = 0; i < 5; i++)
    begin
      k = 4'(i);
      e = {11'h000, k[0], k[1], k[2], k[3], 1'h0};
      xop(1'h1, MODE_POST_INC, 4'h2, 4'h0, 16'h0006, e);
    end
    // A byte write must take the normal path, so a zero step leaves the pointer alone.
    u_dag_ctrl_model.byte_mode(1'h1);
    xop(1'h1, MODE_POST_INC, 4'h2, 4'h0, 16'h0000, 16'h0014);
    u_dag_ctrl_model.byte_mode(1'h0);
    xop(1'h0, MODE_POST_INC, 4'h2, 4'h0, 16'h0002, 16'h0014);
    $display("test bit reverse finished");
    final_report();
  end
endmodule : dag_top_tb
